/* File: verilog/sag_guard.sv */
// anti-streaming guard top: rts/cts gating, duration timer, latch
`timescale 1ns/100ps
module sag_guard #(
   parameter int unsigned TICK_CYCLES = sag_pkg::TICK_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic rts_i,
   input wire logic txd_i,
   input wire logic [2:0] limit_sel_i,
   input wire logic reset_btn_i,
   input wire logic up_rx_i,
   input wire logic dn_rx_i,
   output logic cts_o,
   output logic txd_o,
   output logic up_tx_o,
   output logic dn_tx_o,
   output logic tripped_o
);
   if (TICK_CYCLES < 2) begin : g_tick_chk
      $error("sag_guard: TICK_CYCLES too small");
   end

   ////////////////////////////////////////////////////////////////
   // reset release
   logic [1:0] rst_sh_ff;
   logic rst_n;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sh_ff <= 2'h0;
      end else begin
         rst_sh_ff <= {rst_sh_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sh_ff[1];

   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [7:0] pin_raw;
   logic [7:0] pin_init;
   logic [7:0] pin_s;
   assign pin_raw = {limit_sel_i, reset_btn_i, dn_rx_i, up_rx_i, txd_i,
                     rts_i};
   assign pin_init = {sag_pkg::SEL_DEFAULT, 1'b0, 1'b1, 1'b1, 1'b1,
                      1'b0};
   sag_sync #(.WIDTH(8)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .async_i(pin_raw),
      .init_i(pin_init),
      .sync_o(pin_s)
   );
   logic rts_s;
   logic txd_s;
   logic btn_s;
   logic [2:0] sel_s;
   logic up_rx_s;
   logic dn_rx_s;
   assign rts_s = pin_s[0];
   assign txd_s = pin_s[1];
   assign up_rx_s = pin_s[2];
   assign dn_rx_s = pin_s[3];
   assign btn_s = pin_s[4];
   assign sel_s = pin_s[7:5];

   ////////////////////////////////////////////////////////////////
   // limit decode
   function automatic logic [sag_pkg::SEC_W-1:0] lim_sec(
      input logic [2:0] sel
   );
      logic [sag_pkg::SEC_W-1:0] r;
      r = '0;
      case (sel)
         sag_pkg::SEL_4S: r = 7'(sag_pkg::LIM_4S);
         sag_pkg::SEL_8S: r = 7'(sag_pkg::LIM_4S * 2);
         sag_pkg::SEL_16S: r = 7'(sag_pkg::LIM_4S * 4);
         sag_pkg::SEL_32S: r = 7'(sag_pkg::LIM_4S * 8);
         sag_pkg::SEL_64S: r = 7'(sag_pkg::LIM_64S);
         default: r = '0; // zero means infinite
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////
   // guard state
   typedef enum {SAG_IDLE, SAG_TIMING, SAG_TRIPPED} sag_state_t;
   typedef struct packed {
      sag_state_t state;
      logic [31:0] pre;
      logic [sag_pkg::SEC_W-1:0] secs;
      logic cts;
      logic txd;
      logic up_tx;
      logic dn_tx;
      logic trip;
   } sag_st_t;

   sag_st_t st_ff;
   sag_st_t nxt_st;
   logic active;
   logic [sag_pkg::SEC_W-1:0] limit;

   assign active = rts_s | ~txd_s;
   assign limit = lim_sec(sel_s);

   always_comb begin
      nxt_st = st_ff;
      // repeat optical traffic in both directions unconditionally
      nxt_st.up_tx = dn_rx_s;
      nxt_st.dn_tx = up_rx_s;
      case (st_ff.state)
         SAG_IDLE: begin
            nxt_st.pre = '0;
            nxt_st.secs = '0;
            if (active) begin
               nxt_st.state = SAG_TIMING;
            end
         end
         SAG_TIMING: begin
            if (!active) begin
               nxt_st.state = SAG_IDLE;
               nxt_st.pre = '0;
               nxt_st.secs = '0;
            end else if (limit != '0 && st_ff.secs >= limit) begin
               nxt_st.state = SAG_TRIPPED;
            end else if (st_ff.pre == 32'(TICK_CYCLES - 1)) begin
               nxt_st.pre = '0;
               if (st_ff.secs != '1) begin
                  nxt_st.secs = st_ff.secs + 7'h01;
               end
            end else begin
               nxt_st.pre = st_ff.pre + 32'h1;
            end
         end
         SAG_TRIPPED: begin
            if (btn_s) begin
               nxt_st.state = SAG_IDLE;
               nxt_st.pre = '0;
               nxt_st.secs = '0;
            end
         end
         default: nxt_st.state = SAG_IDLE;
      endcase
      nxt_st.trip = (nxt_st.state == SAG_TRIPPED);
      nxt_st.cts = rts_s & ~nxt_st.trip;
      nxt_st.txd = nxt_st.trip ? 1'b1 : txd_s;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '{state: SAG_IDLE, pre: '0, secs: '0, cts: 1'b0,
                    txd: 1'b1, up_tx: 1'b1, dn_tx: 1'b1, trip: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cts_o = st_ff.cts;
   assign txd_o = st_ff.txd;
   assign up_tx_o = st_ff.up_tx;
   assign dn_tx_o = st_ff.dn_tx;
   assign tripped_o = st_ff.trip;

   ////////////////////////////////////////////////////////////////
   // checks
   property p_trip_blocks;
      @(posedge clk_sys_i) disable iff (!rst_n)
      tripped_o |-> (!cts_o && txd_o);
   endproperty
   a_trip_blocks: assert property (p_trip_blocks)
      else $error("cts or txd not blocked while tripped");

   property p_trip_holds;
      @(posedge clk_sys_i) disable iff (!rst_n)
      (tripped_o && !btn_s) |=> tripped_o;
   endproperty
   a_trip_holds: assert property (p_trip_holds)
      else $error("trip cleared without reset button");

   property p_trip_cause;
      @(posedge clk_sys_i) disable iff (!rst_n)
      $rose(tripped_o) |-> ($past(st_ff.secs) >= $past(limit)
         && $past(limit) != '0);
   endproperty
   a_trip_cause: assert property (p_trip_cause)
      else $error("trip without limit exceeded");

   property p_inf_never;
      @(posedge clk_sys_i) disable iff (!rst_n)
      (limit == '0 && !tripped_o) |=> !tripped_o;
   endproperty
   a_inf_never: assert property (p_inf_never)
      else $error("trip with infinite limit");

   property p_repeat;
      @(posedge clk_sys_i) disable iff (!rst_n)
      ##1 (up_tx_o == $past(dn_rx_s) && dn_tx_o == $past(up_rx_s));
   endproperty
   a_repeat: assert property (p_repeat)
      else $error("optical repeat disturbed");

   property p_cts_follows;
      @(posedge clk_sys_i) disable iff (!rst_n)
      cts_o |-> ($past(rts_s) && !tripped_o);
   endproperty
   a_cts_follows: assert property (p_cts_follows)
      else $error("cts without rts");

   property p_idle_restart;
      @(posedge clk_sys_i) disable iff (!rst_n)
      (st_ff.state == SAG_TIMING && !active) |=> st_ff.secs == '0;
   endproperty
   a_idle_restart: assert property (p_idle_restart)
      else $error("timer not restarted");

   property p_sel_map;
      @(posedge clk_sys_i) disable iff (!rst_n)
      (sel_s == sag_pkg::SEL_16S) |-> limit == 7'h10;
   endproperty
   a_sel_map: assert property (p_sel_map)
      else $error("switch decode wrong");
endmodule

/* File: verilog/sag_pkg.sv */
// constants and encodings for the serial anti-streaming guard
package sag_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_SEC = 1;
   // one-second prescaler count derived from the clock rate
   localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_SEC;
   localparam int unsigned SEL_W = 3;
   // limit switch codes
   localparam logic [2:0] SEL_4S = 3'h0;
   localparam logic [2:0] SEL_8S = 3'h1;
   localparam logic [2:0] SEL_16S = 3'h2;
   localparam logic [2:0] SEL_32S = 3'h3;
   localparam logic [2:0] SEL_64S = 3'h4;
   localparam logic [2:0] SEL_INF = 3'h7;
   localparam logic [2:0] SEL_DEFAULT = SEL_16S;
   localparam int unsigned LIM_4S = 4;
   localparam int unsigned LIM_64S = 64;
   localparam int unsigned SEC_W = 7;
   localparam int unsigned SYNC_N = 3;
endpackage

/* File: verilog/sag_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module sag_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] async_i,
   input wire logic [WIDTH-1:0] init_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
      logic [1:0] fill;
   } sag_sync_st_t;

   sag_sync_st_t st_ff;
   sag_sync_st_t nxt_st;

   if (WIDTH < 1) begin : g_width_chk
      $error("sag_sync: WIDTH must be at least 1");
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = async_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      // strap default until all three stages carry pin data
      if (st_ff.fill != 2'(sag_pkg::SYNC_N)) begin
         nxt_st.fill = st_ff.fill + 2'h1;
         nxt_st.q = init_i;
      end else if (st_ff.s2 == st_ff.s3) begin
         nxt_st.q = st_ff.s3;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // no false edge from the cleared stages right after reset
   assign sync_o = (st_ff.fill == 2'h0) ? init_i : st_ff.q;
endmodule

/* File: verif/sag_ctl_model.sv */
// controller-side model driving request to send and tx data
`timescale 1ns/100ps
module sag_ctl_model (
   input wire logic clk_sys_i,
   input wire logic cts_i,
   input wire logic send_i,
   input wire logic stream_i,
   output logic rts_o,
   output logic txd_o
);
   logic [1:0] ph;
   initial begin
      rts_o = 1'b0;
      txd_o = 1'b1;
      ph = 2'h0;
   end
   always @(posedge clk_sys_i) begin
      rts_o <= send_i;
      ph <= ph + 2'h1;
      // data only once cleared, unless told to stream regardless
      if (send_i && (cts_i || stream_i)) begin
         // one level per four clocks so the pin filter passes it
         if (ph == 2'h3) begin
            txd_o <= ~txd_o;
         end
      end else begin
         txd_o <= 1'b1;
      end
   end
endmodule

/* File: verif/tb_sag_guard.sv */
// self-checking bench for the anti-streaming guard
`timescale 1ns/100ps
module tb_sag_guard;
   localparam int TK = 10;
   logic clk_sys_i, rst_n_i, reset_btn_i, up_rx_i, dn_rx_i, send, stream;
   logic [2:0] limit_sel_i;
   logic rts, txd, cts_o, txd_o, up_tx_o, dn_tx_o, tripped_o;
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   sag_guard #(.TICK_CYCLES(TK)) sag_guard_i (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .rts_i(rts), .txd_i(txd),
      .limit_sel_i(limit_sel_i), .reset_btn_i(reset_btn_i),
      .up_rx_i(up_rx_i), .dn_rx_i(dn_rx_i), .cts_o(cts_o),
      .txd_o(txd_o), .up_tx_o(up_tx_o), .dn_tx_o(dn_tx_o),
      .tripped_o(tripped_o));
   sag_ctl_model sag_ctl_model_i (.clk_sys_i(clk_sys_i), .cts_i(cts_o),
      .send_i(send), .stream_i(stream), .rts_o(rts), .txd_o(txd));
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(string name, logic seen, logic exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic go(logic s, logic st);
      @(posedge clk_sys_i);
      send <= s;
      stream <= st;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // two short bursts with idle between must not add up
   task automatic t_handshake();
      logic low_seen;
      low_seen = 1'b0;
      @(posedge clk_sys_i);
      limit_sel_i <= sag_pkg::SEL_4S;
      wt(10);
      go(1'b1, 1'b0);
      wt(10);
      chk("cts_o", cts_o, 1'b1);
      repeat (8) begin
         wt(1);
         if (txd_o === 1'b0) low_seen = 1'b1;
      end
      chk("txd_o passes", low_seen, 1'b1);
      wt(7);
      go(1'b0, 1'b0);
      wt(10);
      chk("cts_o", cts_o, 1'b0);
      go(1'b1, 1'b0);
      wt(30);
      chk("tripped_o", tripped_o, 1'b0);
      chk("cts_o again", cts_o, 1'b1);
      go(1'b0, 1'b0);
      wt(10);
   endtask
   task automatic t_trip(logic [2:0] code, int lim);
      @(posedge clk_sys_i);
      limit_sel_i <= code;
      wt(10);
      go(1'b1, 1'b1);
      wt(lim * TK);
      chk("tripped_o early", tripped_o, 1'b0);
      for (int i = 0; i < TK && tripped_o !== 1'b1; i++) wt(1);
      chk("tripped_o", tripped_o, 1'b1);
      repeat (4) begin
         wt(1);
         chk("cts_o", cts_o, 1'b0);
         chk("txd_o", txd_o, 1'b1);
      end
      go(1'b0, 1'b0);
      wt(10);
      chk("tripped_o held", tripped_o, 1'b1);
      for (int v = 0; v < 2; v++) begin
         @(posedge clk_sys_i);
         up_rx_i <= v[0];
         dn_rx_i <= ~v[0];
         wt(8);
         chk("dn_tx_o", dn_tx_o, v[0]);
         chk("up_tx_o", up_tx_o, ~v[0]);
      end
      @(posedge clk_sys_i);
      reset_btn_i <= 1'b1;
      wt(8);
      @(posedge clk_sys_i);
      reset_btn_i <= 1'b0;
      wt(8);
      chk("tripped_o cleared", tripped_o, 1'b0);
   endtask
   task automatic t_inf(logic [2:0] code);
      @(posedge clk_sys_i);
      limit_sel_i <= code;
      go(1'b1, 1'b0);
      wt(700);
      chk("tripped_o inf", tripped_o, 1'b0);
      chk("cts_o inf", cts_o, 1'b1);
      go(1'b0, 1'b0);
      wt(10);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n_i = 1'b0;
      reset_btn_i = 1'b0;
      up_rx_i = 1'b1;
      dn_rx_i = 1'b1;
      send = 1'b0;
      stream = 1'b0;
      limit_sel_i = sag_pkg::SEL_DEFAULT;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      wt(10);
      t_handshake();
      for (int c = 0; c < 5; c++) t_trip(c[2:0], 4 << c);
      for (int c = 5; c < 8; c++) t_inf(c[2:0]);
      report_and_stop();
   end
endmodule
